/* File: rtl/evl_logger.sv */
// evl_logger.sv: event logger top with wishbone registers and ring store
`timescale 1ns/1ps
`default_nettype none
`include "evl_params.svh"
module evl_logger
    import evl_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [`EVL_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic [`EVL_NSRC-1:0]   src_level,
    input  wire logic [`EVL_TS_W-1:0]   ts_value,
    output logic [`EVL_TSEL_W-1:0]      timestamp_timer_select,
    output logic                        has_unread_flag,
    output logic                        buffer_full_flag,
    output logic                        watermark_flag,
    output logic                        seq_trigger,
    output logic                        dsp_start_trigger,
    output logic                        gpio_status
);
    // the clock is whichever of the dsp or timer clock is live,
    // chosen outside; ts_value is the selected timer's count
    evl_chan_if ch ();

    logic                    logger_enable;
    logic [`EVL_CNT_W-1:0]   watermark_level;
    logic [`EVL_PTR_W-1:0]   write_index;
    logic [`EVL_PTR_W-1:0]   read_index;
    logic [`EVL_PTR_W-1:0]   next_read_index;
    evl_fill_e               fill;
    logic [`EVL_NCH-1:0]     chan_enable;
    logic [`EVL_NCH-1:0]     chan_edge_polarity;
    logic [`EVL_NCH-1:0]     chan_debounce;
    evl_id_t                 chan_source_select [`EVL_NCH];
    evl_entry_s              store [`EVL_DEPTH];
    logic                    unread_d;

    // bus decode
    logic                    bus_req;
    logic                    bus_wr;
    logic [`EVL_ADR_W-1:0]   adr;
    logic                    is_chan;
    logic                    is_store;
    logic [`EVL_PTR_W-1:0]   slot;
    logic                    logger_clear;
    logic                    read_index_short_wr;
    logic [31:0]             rdata;

    // logging path
    logic [`EVL_NCH-1:0]     grant;
    logic [`EVL_PTR_W-1:0]   win;
    logic                    fire;
    logic [`EVL_CNT_W-1:0]   unread_cnt;
    logic [`EVL_CNT_W-1:0]   free_cnt;

    evl_chan_bank u_bank (
        .clk       (clk),
        .rstn      (rstn),
        .src_level (src_level),
        .ch        (ch.bank)
    );

    // channel configuration into the bank
    assign ch.run   = logger_enable;
    assign ch.hold  = (fill == EVL_HELD);
    assign ch.clr   = logger_clear;
    assign ch.ena   = chan_enable; // [RQ1]
    assign ch.pol   = chan_edge_polarity;
    assign ch.db    = chan_debounce;
    assign ch.grant = grant;
    assign ch.sel   = chan_source_select;

    // the master holds its request until ack, so the edge that
    // carries ack is the one edge where a write lands
    assign bus_req  = wb_cyc_i && wb_stb_i;
    assign bus_wr   = bus_req && wb_we_i && wb_ack_o;
    assign adr      = {wb_adr_i[`EVL_ADR_W-1:2], 2'b00};
    assign is_chan  = (adr[7:6] == 2'b01);
    assign is_store = adr[7];
    assign slot     = is_store ? adr[6:3] : adr[5:2];

    assign logger_clear = bus_wr && adr == `EVL_A_CTRL && wb_sel_i[0] &&
                          wb_dat_i[`EVL_CTRL_CLR]; // [RQ24]
    assign read_index_short_wr      = bus_wr && adr == `EVL_A_READ_INDEX_SHORT && wb_sel_i[0];
    assign next_read_index = read_index_short_wr ? wb_dat_i[`EVL_PTR_W-1:0]
                                     : read_index;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req && !wb_ack_o;
    end

    // read data latched with the ack; unmapped words read zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_req && !wb_ack_o)
            wb_dat_o <= rdata;
    end

    // read mux; every slot is open to software at any time
    always_comb begin
        rdata = 32'h0000_0000;
        if (is_store) begin
            if (!adr[2]) begin
                rdata[`EVL_ID_W-1:0] = store[slot].id; // [RQ9]
                rdata[`EVL_CH_POL]   = store[slot].pol;
            end else begin
                rdata = store[slot].ts;
            end
        end else if (is_chan) begin
            rdata[`EVL_ID_W-1:0] = chan_source_select[slot];
            rdata[`EVL_CH_POL]   = chan_edge_polarity[slot];
            rdata[`EVL_CH_DB]    = chan_debounce[slot];
            rdata[`EVL_CH_ENA]   = chan_enable[slot];
        end else begin
            unique case (adr)
                `EVL_A_CTRL: begin
                    rdata[`EVL_CTRL_ENA] = logger_enable;
                    rdata[`EVL_CTRL_TSEL +: `EVL_TSEL_W] =
                        timestamp_timer_select;
                end
                `EVL_A_STAT: begin
                    rdata[`EVL_ST_NE]   = has_unread_flag;
                    rdata[`EVL_ST_FULL] = buffer_full_flag;
                    rdata[`EVL_ST_WM]   = watermark_flag;
                    rdata[`EVL_ST_CNT +: `EVL_CNT_W] = unread_cnt;
                end
                `EVL_A_WMARK: rdata[`EVL_CNT_W-1:0] = watermark_level;
                `EVL_A_WRITE_INDEX_SHORT:  rdata[`EVL_PTR_W-1:0] = write_index;
                `EVL_A_READ_INDEX_SHORT:  rdata[`EVL_PTR_W-1:0] = read_index;
                default:      rdata = 32'h0000_0000;
            endcase
        end
    end

    // logger control; the timer choice is only to change while stopped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            logger_enable          <= 1'b0;
            timestamp_timer_select <= '0;
        end else if (bus_wr && adr == `EVL_A_CTRL && wb_sel_i[0]) begin
            logger_enable          <= wb_dat_i[`EVL_CTRL_ENA];
            timestamp_timer_select <=
                wb_dat_i[`EVL_CTRL_TSEL +: `EVL_TSEL_W];
        end
    end

    // watermark level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            watermark_level <= `EVL_WM_RST;
        else if (bus_wr && adr == `EVL_A_WMARK && wb_sel_i[0])
            watermark_level <= wb_dat_i[`EVL_CNT_W-1:0]; // [RQ13]
    end

    // channel setup; the bank trusts software to disable a channel
    // before retargeting it, so no interlock is spent here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chan_enable        <= '0;
            chan_edge_polarity <= '0;
            chan_debounce      <= '0;
            for (int k = 0; k < `EVL_NCH; k++)
                chan_source_select[k] <= '0;
        end else if (bus_wr && is_chan) begin
            if (wb_sel_i[0])
                chan_source_select[slot][7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) begin
                chan_source_select[slot][8] <= wb_dat_i[8]; // [RQ2]
                chan_edge_polarity[slot] <= wb_dat_i[`EVL_CH_POL];
                chan_debounce[slot]      <= wb_dat_i[`EVL_CH_DB];
                chan_enable[slot]        <= wb_dat_i[`EVL_CH_ENA]; // [RQ1]
            end
        end
    end

    // lowest pending channel wins; the rest stay queued in the bank
    assign grant = (logger_enable && fill == EVL_OPEN) ?
                   (ch.pend & (~ch.pend + 16'h0001)) : '0; // [RQ23]
    assign fire  = |grant;

    always_comb begin
        win = '0;
        for (int k = `EVL_NCH - 1; k >= 0; k--) begin
            if (ch.pend[k])
                win = k[`EVL_PTR_W-1:0];
        end
    end

    // ring store; cleared whole by logger clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < `EVL_DEPTH; k++)
                store[k] <= '0;
        end else if (logger_clear) begin
            for (int k = 0; k < `EVL_DEPTH; k++)
                store[k] <= '0; // [RQ24]
        end else if (fire) begin
            store[write_index].id  <= chan_source_select[win]; // [RQ7]
            store[write_index].pol <= chan_edge_polarity[win];
            store[write_index].ts  <= ts_value; // [RQ25]
        end
    end

    // write index steps once per logged event and wraps at 15
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            write_index <= '0;
        else if (logger_clear)
            write_index <= '0; // [RQ8]
        else if (fire)
            write_index <= write_index + 4'h1; // [RQ6]
    end

    // read index is owned by software; any value, any step size
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            read_index <= '0;
        else if (logger_clear)
            read_index <= '0; // [RQ8]
        else
            read_index <= next_read_index; // [RQ11]
    end

    // full state: set when the next slot would be the first unread,
    // left by logger clear or by a read index write that changes the value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            fill <= EVL_OPEN;
        else if (logger_clear)
            fill <= EVL_OPEN;
        else begin
            unique case (fill)
                EVL_OPEN:
                    if (fire && write_index + 4'h1 == next_read_index)
                        fill <= EVL_HELD; // [RQ14] [RQ6]
                EVL_HELD:
                    if (read_index_short_wr && next_read_index != read_index)
                        fill <= EVL_OPEN; // [RQ15] [RQ16]
            endcase
        end
    end

    // equal indices read as 16 unread when held full
    assign unread_cnt = (fill == EVL_HELD) ? 5'h10 :
                        {1'b0, write_index - read_index}; // [RQ10]
    assign free_cnt   = 5'h10 - unread_cnt;

    // status flags, combinational from the indices, the fill state and the watermark level every cycle
    assign buffer_full_flag = (fill == EVL_HELD); // [RQ14] [RQ18]
    assign has_unread_flag  = buffer_full_flag ||
                              (write_index != read_index); // [RQ12] [RQ18]
    assign watermark_flag   = (free_cnt <= watermark_level); // [RQ26] [RQ13]

    // rise detector for the sequencer kick
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            unread_d <= 1'b0;
        else
            unread_d <= has_unread_flag;
    end

    assign seq_trigger       = has_unread_flag && !unread_d; // [RQ17]
    assign dsp_start_trigger = has_unread_flag; // [RQ20]
    assign gpio_status       = has_unread_flag; // [RQ19]

    // checks on the logging path
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_one_grant;
        $onehot0(grant);
    endproperty
    a_one_grant: assert property (p_one_grant) // [RQ23]
        else $error("more than one channel granted");

    property p_lowest_first;
        fire |-> ((grant - 16'h0001) & ch.pend) == 16'h0000;
    endproperty
    a_lowest_first: assert property (p_lowest_first) // [RQ23]
        else $error("lower channel skipped");

    property p_index_step;
        fire && !logger_clear |=> write_index == $past(write_index) + 4'h1;
    endproperty
    a_index_step: assert property (p_index_step) // [RQ6]
        else $error("write index did not step");

    // watch the index itself, not the grant gate that blocks it
    property p_no_log_full;
        buffer_full_flag && !logger_clear |=> $stable(write_index);
    endproperty
    a_no_log_full: assert property (p_no_log_full) // [RQ14]
        else $error("event logged while full");

    property p_goes_full;
        fire && !logger_clear && !read_index_short_wr &&
        write_index + 4'h1 == read_index |=> buffer_full_flag;
    endproperty
    a_goes_full: assert property (p_goes_full) // [RQ14]
        else $error("full not raised");

    sequence s_same_read_index_short;
        buffer_full_flag && read_index_short_wr && next_read_index == read_index &&
        !logger_clear;
    endsequence
    sequence s_new_read_index_short;
        buffer_full_flag && read_index_short_wr && next_read_index != read_index &&
        !logger_clear;
    endsequence

    property p_same_keeps;
        s_same_read_index_short |=> buffer_full_flag;
    endproperty
    a_same_keeps: assert property (p_same_keeps) // [RQ15]
        else $error("same read index released full");

    property p_new_resumes;
        s_new_read_index_short |=> !buffer_full_flag ##1 1'b1;
    endproperty
    a_new_resumes: assert property (p_new_resumes) // [RQ15]
        else $error("new read index did not release full");

    property p_clear;
        logger_clear |=> write_index == 4'h0 && read_index == 4'h0 &&
                         !has_unread_flag && !buffer_full_flag;
    endproperty
    a_clear: assert property (p_clear) // [RQ24]
        else $error("clear left state behind");

    sequence s_unread_rise;
        !has_unread_flag ##1 has_unread_flag;
    endsequence
    property p_seq_kick;
        s_unread_rise |-> seq_trigger ##1 !seq_trigger;
    endproperty
    a_seq_kick: assert property (p_seq_kick) // [RQ17]
        else $error("sequencer trigger not a single pulse");

    property p_logged_unread;
        fire && !logger_clear |=> has_unread_flag;
    endproperty
    a_logged_unread: assert property (p_logged_unread) // [RQ12]
        else $error("not-empty missing after log");
endmodule
`default_nettype wire

/* File: rtl/evl_params.svh */
// evl_params.svh: constants of the event logger bank
// What this block does
// RQ1: each channel has its own enable, usable while the logger runs
// RQ2: software disables a channel before changing its select, polarity, debounce
// RQ3: software uses two channels on one source to catch both edges
// RQ4: rising channel already high at logger enable logs one initial event
// RQ5: falling channel low at logger enable logs an initial event
// RQ6: matching edges fill a 16-entry ring; unread entries never overwritten
// RQ7: entry holds source id, edge polarity and 32-bit timestamp
// RQ8: write index names next slot; read index is writable; both reset to 0
// RQ9: all entries stay readable in any order; no ordering enforced
// RQ10: unread count is write minus read index modulo 16
// RQ11: software advances read index by the number of entries consumed
// RQ12: not-empty flag is set while any unread entry exists
// RQ13: watermark flag rises when free slots reach programmed level
// RQ14: full flag at 16 unread; further events neither logged nor flagged
// RQ15: after full, logging resumes only on a differing read index write
// RQ16: software writes an intermediate read index before matching write index
// RQ17: rise of not-empty triggers the write sequencer of this logger
// RQ18: full, not-empty and watermark flags feed the interrupt logic
// RQ19: logger status is offered as a pin-routable signal
// RQ20: not-empty is offered as a firmware start trigger
// RQ21: single-edge sources give events only with rising polarity
// RQ22: source codes follow a fixed map with single or dual edge type
// RQ23: one event per cycle, lowest channel first, others stay queued
// RQ24: writing 1 to logger clear wipes flags, indices and contents
// RQ25: clock and timestamp come from the chosen timer domain
// RQ26: watermark is free slots at or below level, every cycle
`ifndef EVL_PARAMS_SVH
`define EVL_PARAMS_SVH
`define EVL_NCH       16
`define EVL_DEPTH     16
`define EVL_PTR_W     4
`define EVL_CNT_W     5
`define EVL_ID_W      9
`define EVL_NSRC      512
`define EVL_TS_W      32
`define EVL_TSEL_W    3
`define EVL_WM_RST    5'h00
`define EVL_ADR_W     8
`define EVL_A_CTRL    8'h00
`define EVL_A_STAT    8'h04
`define EVL_A_WMARK   8'h08
`define EVL_A_WRITE_INDEX_SHORT    8'h0C
`define EVL_A_READ_INDEX_SHORT    8'h10
`define EVL_CTRL_ENA  0
`define EVL_CTRL_CLR  1
`define EVL_CTRL_TSEL 4
`define EVL_CH_POL    12
`define EVL_CH_DB     13
`define EVL_CH_ENA    15
`define EVL_ST_NE     0
`define EVL_ST_FULL   1
`define EVL_ST_WM     2
`define EVL_ST_CNT    4
`define EVL_ID_ASRC_LO  9'h088
`define EVL_ID_ASRC_HI  9'h08B
`define EVL_ID_SPK_LO   9'h0B6
`define EVL_ID_SPK_HI   9'h0B7
`define EVL_ID_SPK_SD   9'h0E0
`define EVL_ID_GPIO_LO  9'h100
`define EVL_ID_GPIO_HI  9'h127
`define EVL_ID_BUSY_LO  9'h1D0
`define EVL_ID_BUSY_HI  9'h1D6
`endif

/* File: rtl/evl_pkg.sv */
// evl_pkg.sv: types and the source edge map of the event logger
package evl_pkg;
`include "evl_params.svh"
    typedef logic [`EVL_ID_W-1:0] evl_id_t;
    typedef struct packed {
        evl_id_t                id;
        logic                   pol;
        logic [`EVL_TS_W-1:0]   ts;
    } evl_entry_s;
    typedef enum logic {EVL_OPEN, EVL_HELD} evl_fill_e;
    // dual-edge sources; every other code is single edge
    function automatic logic evl_dual_edge(input evl_id_t id);
        return (id >= `EVL_ID_ASRC_LO && id <= `EVL_ID_ASRC_HI) ||
               (id >= `EVL_ID_SPK_LO && id <= `EVL_ID_SPK_HI) ||
               (id == `EVL_ID_SPK_SD) ||
               (id >= `EVL_ID_GPIO_LO && id <= `EVL_ID_GPIO_HI) ||
               (id >= `EVL_ID_BUSY_LO && id <= `EVL_ID_BUSY_HI);
    endfunction
endpackage

/* File: rtl/evl_chan_if.sv */
// evl_chan_if.sv: channel bank link between control and edge detectors
`timescale 1ns/1ps
`default_nettype none
`include "evl_params.svh"
interface evl_chan_if;
    import evl_pkg::*;
    logic                  run;
    logic                  hold;
    logic                  clr;
    logic [`EVL_NCH-1:0]   ena;
    logic [`EVL_NCH-1:0]   pol;
    logic [`EVL_NCH-1:0]   db;
    logic [`EVL_NCH-1:0]   grant;
    logic [`EVL_NCH-1:0]   pend;
    evl_id_t               sel [`EVL_NCH];
    modport bank (input run, hold, clr, ena, pol, db, grant, sel,
                  output pend);
    modport ctl  (output run, hold, clr, ena, pol, db, grant, sel,
                  input pend);
endinterface
`default_nettype wire

/* File: rtl/evl_chan_bank.sv */
// evl_chan_bank.sv: per-channel source pick, debounce, edge and queue
`timescale 1ns/1ps
`default_nettype none
`include "evl_params.svh"
module evl_chan_bank
    import evl_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic [`EVL_NSRC-1:0] src_level,
    evl_chan_if.bank                  ch
);
    for (genvar i = 0; i < `EVL_NCH; i++) begin : g_ch
        logic raw;
        logic raw_d;
        logic lvl;
        logic prev;
        logic pol_ok;
        logic hit;
        logic pend;
        assign raw = src_level[ch.sel[i]];
        assign pol_ok = !ch.pol[i] || evl_dual_edge(ch.sel[i]); // [RQ21] [RQ22]
        // debounce takes a level only after two equal samples
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                raw_d <= 1'b0;
                lvl   <= 1'b0;
            end else begin
                raw_d <= raw;
                if (!ch.db[i] || raw == raw_d)
                    lvl <= raw;
            end
        end
        // while stopped, prev sits at the inactive level so the
        // state seen at enable reads as an edge
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn)
                prev <= 1'b0;
            else if (!ch.run)
                prev <= ch.pol[i]; // [RQ4] [RQ5]
            else
                prev <= lvl;
        end
        // full drops edges outright, nothing is flagged
        assign hit = ch.run && ch.ena[i] && !ch.hold && pol_ok && // [RQ1] [RQ14]
                     (ch.pol[i] ? (prev && !lvl) : (!prev && lvl));
        // a queued channel ignores repeats; a new hit beats the grant
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn)
                pend <= 1'b0;
            else if (ch.clr || !ch.ena[i] || !ch.run)
                pend <= 1'b0;
            else
                pend <= (pend && !ch.grant[i]) || hit; // [RQ23]
        end
        assign ch.pend[i] = pend;
    end
endmodule
`default_nettype wire

/* File: tb/evl_src_model.sv */
// evl_src_model.sv: behavioural model of the watched signal sources
`timescale 1ns/1ps
`default_nettype none
`include "evl_params.svh"
module evl_src_model
    import evl_pkg::*;
(
    input  wire logic             clk,
    output logic [`EVL_NSRC-1:0]  src_level
);
    initial begin
        src_level = '0;
    end
    // levels move only just after an edge, like a synchronous source
    task automatic set_lvl(input int id, input logic v);
        @(posedge clk);
        src_level[id] <= v;
    endtask
    // low then high; the spacing lets each queued event drain first
    task automatic pulse(input int id);
        set_lvl(id, 1'b0);
        repeat (2) @(posedge clk);
        set_lvl(id, 1'b1);
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/evl_logger_tb_top.sv */
// evl_logger_tb_top.sv: self-checking bench of the event logger
`timescale 1ns/1ps
`default_nettype none
`include "evl_params.svh"
module evl_logger_tb_top;
    import evl_pkg::*;
    logic                  clk, rstn, cyc, stb, we;
    logic [7:0]            adr;
    logic [31:0]           wdat, rd, dat_o, ts, ts2;
    logic                  ack, ne, full, wm, seq, dsp, gpo;
    logic [`EVL_NSRC-1:0]  src;
    logic [`EVL_TS_W-1:0]  ts_value;
    logic [3:0]            sel;
    logic [3:0]            lanes = 4'hF;
    logic [`EVL_TSEL_W-1:0] tsel;
    int                    fails = 0, compares = 0, seq_n = 0;
    evl_src_model msrc (.clk(clk), .src_level(src));
    evl_logger dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .src_level(src),
        .ts_value(ts_value), .timestamp_timer_select(tsel),
        .has_unread_flag(ne), .buffer_full_flag(full), .watermark_flag(wm),
        .seq_trigger(seq), .dsp_start_trigger(dsp), .gpio_status(gpo));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // one-cycle pulses are counted at the edge where they stand
    always @(posedge clk) begin
        if (seq === 1'b1) seq_n <= seq_n + 1;
    end
    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // status word from an unread count and the watermark state
    function automatic logic [31:0] stat_word(input int cnt, input logic w);
        return (32'(cnt) << `EVL_ST_CNT) | 32'(cnt != 0) |
               (32'(cnt == 16) << `EVL_ST_FULL) | (32'(w) << `EVL_ST_WM);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= lanes;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("ack", 1, 0);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    initial begin
        #100000;
        fails++;
        final_report();
    end
    initial begin
        {rstn, cyc, stb, we, sel, adr, wdat, ts_value} = '0;
        void'($urandom(33425));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rchk(8'h04, 32'h0);
        rchk(8'h0C, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'hFC, 32'h0);
        ts = $urandom;
        ts2 = $urandom;
        ts_value <= ts;
        msrc.set_lvl(256, 1'b1);
        msrc.set_lvl(257, 1'b1);
        // channels set while disabled; falling on a timer never logs
        wb(1'b1, 8'h40, 32'h8100);
        wb(1'b1, 8'h44, 32'h8101);
        wb(1'b1, 8'h48, 32'h9140);
        wb(1'b1, 8'h4C, 32'h9102);
        // timer picked while stopped, then the logger started
        wb(1'b1, 8'h00, 32'h50);
        wb(1'b1, 8'h00, 32'h51);
        chk("tsel", 5, 32'(tsel));
        repeat (8) @(posedge clk);
        rchk(8'h0C, 32'h3);
        rchk(8'h04, stat_word(3, 1'b0));
        rchk(8'h94, ts);
        rchk(8'h90, 32'h1102);
        rchk(8'h88, 32'h101);
        rchk(8'h80, 32'h100);
        chk("pins", 3'b111, {ne, dsp, gpo});
        chk("seq", 1, 32'(seq_n));
        // the level lands on the ack edge; look once it has settled
        wb(1'b1, 8'h08, 32'd14);
        @(negedge clk);
        chk("wm", 1, wm);
        wb(1'b1, 8'h08, 32'd12);
        @(negedge clk);
        chk("wm", 0, wm);
        repeat (13) msrc.pulse(256);
        rchk(8'h04, stat_word(16, 1'b1));
        chk("full", 1, full);
        @(posedge clk);
        ts_value <= ts2;
        msrc.pulse(256);
        rchk(8'h84, ts);
        rchk(8'h0C, 32'h0);
        wb(1'b1, 8'h10, 32'h0);
        rchk(8'h04, stat_word(16, 1'b1));
        wb(1'b1, 8'h10, 32'h5);
        rchk(8'h04, stat_word(11, 1'b1));
        msrc.pulse(256);
        rchk(8'h0C, 32'h1);
        rchk(8'h84, ts2);
        wb(1'b1, 8'h10, 32'h1);
        rchk(8'h04, 32'h0);
        // read index needs lane 0; without it the write is dropped
        lanes = 4'hE;
        wb(1'b1, 8'h10, 32'h7);
        lanes = 4'hF;
        rchk(8'h10, 32'h1);
        wb(1'b1, 8'h40, 32'h0100);
        wb(1'b1, 8'h48, 32'h1101);
        wb(1'b1, 8'h48, 32'h9101);
        msrc.pulse(256);
        msrc.pulse(257);
        rchk(8'h0C, 32'h3);
        rchk(8'h88, 32'h1101);
        rchk(8'h90, 32'h101);
        chk("seq", 2, 32'(seq_n));
        wb(1'b1, 8'h00, 32'h2);
        rchk(8'h0C, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'h04, 32'h0);
        rchk(8'h88, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
